// *** shared/rtcca_consts.svh ***
`ifndef RTCCA_CONSTS_SVH
`define RTCCA_CONSTS_SVH

// Register byte offsets on the APB word map
`define RTCCA_OFF_STAT1 8'h00
`define RTCCA_OFF_STAT2 8'h04
`define RTCCA_OFF_YEAR  8'h08
`define RTCCA_OFF_MONTH 8'h0C
`define RTCCA_OFF_DAY   8'h10
`define RTCCA_OFF_WDAY  8'h14
`define RTCCA_OFF_HOUR  8'h18
`define RTCCA_OFF_MIN   8'h1C
`define RTCCA_OFF_SEC   8'h20
`define RTCCA_OFF_PA0   8'h24
`define RTCCA_OFF_PA1   8'h28
`define RTCCA_OFF_PA2   8'h2C
`define RTCCA_OFF_PB0   8'h30
`define RTCCA_OFF_PB1   8'h34
`define RTCCA_OFF_PB2   8'h38

// First status register bit positions
`define RTCCA_S1_INIT  7
`define RTCCA_S1_FMT24 6
`define RTCCA_S1_SCRH  5
`define RTCCA_S1_SCRL  4
`define RTCCA_S1_ALA   3
`define RTCCA_S1_ALB   2
`define RTCCA_S1_LOW   1
`define RTCCA_S1_PWR   0

// Reset values: power-on and software initialisation
`define RTCCA_POR_STAT2  8'h80
`define RTCCA_POR_PA0    8'h80
`define RTCCA_INIT_STAT2 8'h00
`define RTCCA_INIT_PARAM 8'h00
`define RTCCA_INIT_YEAR  8'h00
`define RTCCA_INIT_MONTH 5'h01
`define RTCCA_INIT_DAY   6'h01

// Oscillator division: 32768 ticks per second
`define RTCCA_OSC_HZ     32768
`define RTCCA_PRE_LAST   15'h7FFF
`define RTCCA_PER2_TICKS 15'h0100

`endif

// *** shared/rtcca_pkg.sv ***
package rtcca_pkg;

  // Running calendar, BCD with weight 1 in bit 0
  typedef struct packed {
    logic [7:0] year;
    logic [4:0] month;
    logic [5:0] day;
    logic [2:0] wday;
    logic [5:0] hour;
    logic       pm;
    logic [6:0] min;
    logic [6:0] sec;
  } rtcca_cal_t;

  typedef enum logic [2:0] {
    OM_OFF, OM_FREQ, OM_EDGE, OM_PER1, OM_ALARM, OM_PER2, OM_OSC
  } rtcca_mode_t;

  // Bus bit n carries pin-order bit Bn, weight 1 sits in B7
  function automatic logic [7:0] rtcca_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
      r[i] = v[7-i];
    return r;
  endfunction

  function automatic logic [7:0] rtcca_bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    return r;
  endfunction

  // Years 00..99 map to 2000..2099, so every fourth year leaps
  function automatic logic [5:0] rtcca_month_len(input logic [4:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    unique case (m)
      5'h02:                      rtcca_month_len = leap ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: rtcca_month_len = 6'h30;
      default:                    rtcca_month_len = 6'h31;
    endcase
  endfunction

  function automatic rtcca_mode_t rtcca_mode_of(input logic is_a, input logic osc,
                                                input logic ae, input logic me,
                                                input logic fe);
    rtcca_mode_t m;
    m = OM_OFF;
    if (osc && is_a)
      m = OM_OSC;
    else if (!me && fe)
      m = OM_FREQ;
    else if (me && !fe)
      m = OM_EDGE;
    else if (me && fe)
      m = (ae && is_a) ? OM_PER2 : OM_PER1;
    else if (ae)
      m = OM_ALARM;
    return m;
  endfunction

endpackage

// *** rtl/rtcca_regs.sv ***
// Summary of operation
// - Calendar kept as seven BCD bytes: year, month, day, weekday, hour, minute, second.
// - Full calendar access covers year to second, weight-1 bit in B7.
// - Time-only access covers hour, minute, second and skips the date.
// - Read starting at year or hour copies a snapshot; a calendar access copies again at hour, so a carry between the two can split date from time.
// - Year holds 00 to 99; calendar valid through 2099.
// - Day rolls after 31, 30, or 29/28 in February by leap year.
// - Weekday counts 00 to 06 then wraps to 00.
// - Afternoon bit written in 12-hour; derived from hour in 24-hour mode.
// - Minute and second hold BCD 00 to 59 in seven bits.
// - Unused bits ignore writes and read as zero.
// - Two scratch bits in first status register are plain storage.
// - Alarm flags set on match, read-only, cleared by reading.
// - Power-up flag set at power-on, cleared by reading.
// - Supply-low flag sticky once set, even after supply recovers.
// - Status bit B6 selects 12-hour (0) or 24-hour (1).
// - Writing 1 to B7 initialises the device; it reads 0.
// - Output B mode decoded from its alarm, minute and frequency enables.
// - Output A like B; all enables give mode 2; passthrough overrides.
// - Parameter bytes serve as alarm time or frequency select by mode.
// - Valid bit B0 of each alarm byte includes that field in matching.
// - Target registers: two status, calendar, time-only, two parameter sets.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`include "rtcca_consts.svh"
module rtcca_regs
  import rtcca_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              osc_32k,
  input  wire logic              supply_low_det,
  output logic                   out_a_n,
  output logic                   out_b_n
);

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic        pready_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  wire  [7:0]  a8    = paddr[7:0];
  wire         setup = psel & ~penable;
  wire         done  = psel & penable & pready_ff;
  wire  [7:0]  wb    = rtcca_rev8(pwdata[7:0]);
  wire         wdone = done & pwrite;
  wire         rdone = done & ~pwrite;

  wire hit_s1  = (a8 == `RTCCA_OFF_STAT1);
  wire hit_s2  = (a8 == `RTCCA_OFF_STAT2);
  wire hit_yr  = (a8 == `RTCCA_OFF_YEAR);
  wire hit_mo  = (a8 == `RTCCA_OFF_MONTH);
  wire hit_dy  = (a8 == `RTCCA_OFF_DAY);
  wire hit_wd  = (a8 == `RTCCA_OFF_WDAY);
  wire hit_hr  = (a8 == `RTCCA_OFF_HOUR);
  wire hit_mi  = (a8 == `RTCCA_OFF_MIN);
  wire hit_se  = (a8 == `RTCCA_OFF_SEC);
  wire [2:0] hit_pa = {a8 == `RTCCA_OFF_PA2, a8 == `RTCCA_OFF_PA1, a8 == `RTCCA_OFF_PA0};
  wire [2:0] hit_pb = {a8 == `RTCCA_OFF_PB2, a8 == `RTCCA_OFF_PB1, a8 == `RTCCA_OFF_PB0};
  wire hit_any = hit_s1 | hit_s2 | hit_yr | hit_mo | hit_dy | hit_wd | hit_hr | hit_mi
               | hit_se | (|hit_pa) | (|hit_pb);
  wire addr_ok = hit_any & (paddr[ADDR_W-1:2] == {{(ADDR_W-8){1'b0}}, a8[7:2]});

  wire init = wdone & addr_ok & hit_s1 & pwdata[`RTCCA_S1_INIT];

  ////////////////////////////////////////////////////////////////////////
  // Status and mode registers

  logic       fmt24_ff;
  logic [1:0] scratch_ff;
  logic [1:0] alarm_flag_ff;
  logic       low_ff;
  logic       pwr_ff;
  logic [7:0] stat2_ff;
  logic [7:0] par_ff [2][3];

  wire         s1_rd = rdone & addr_ok & hit_s1;
  wire         s1_wr = wdone & addr_ok & hit_s1;
  wire         s2_wr = wdone & addr_ok & hit_s2;
  wire [1:0]   alarm_set;
  wire [1:0]   al_clr = s1_rd ? {prdata_ff[`RTCCA_S1_ALA], prdata_ff[`RTCCA_S1_ALB]} : 2'b00;
  wire [1:0][2:0] par_wr = {hit_pb & {3{wdone & addr_ok}}, hit_pa & {3{wdone & addr_ok}}};

  // Hour format and scratch storage are not cleared by initialisation; the initialising write loads them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fmt24_ff   <= 1'b0;
      scratch_ff <= 2'b00;
    end
    else if (s1_wr)
    begin
      fmt24_ff   <= pwdata[`RTCCA_S1_FMT24];
      scratch_ff <= pwdata[`RTCCA_S1_SCRH:`RTCCA_S1_SCRL];
    end
  end

  // Flags: a set in the clearing cycle wins, only bits read as 1 clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alarm_flag_ff <= 2'b00;
      low_ff        <= 1'b0;
      pwr_ff        <= 1'b1;
    end
    else
    begin
      alarm_flag_ff <= init ? 2'b00 : (alarm_set | (alarm_flag_ff & ~al_clr));
      low_ff        <= supply_low_det | (low_ff & ~(init | (s1_rd & prdata_ff[`RTCCA_S1_LOW])));
      // Power-up flag clears on read or init
      pwr_ff        <= pwr_ff & ~(init | (s1_rd & prdata_ff[`RTCCA_S1_PWR]));
    end
  end

  // Output modes; test bit is stored but has no function
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat2_ff <= `RTCCA_POR_STAT2;
    else if (init)
      stat2_ff <= `RTCCA_INIT_STAT2;
    else if (s2_wr)
      stat2_ff <= pwdata[7:0];
  end

  // Parameter bytes, shared by alarm and frequency use
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      par_ff <= '{'{`RTCCA_POR_PA0, `RTCCA_INIT_PARAM, `RTCCA_INIT_PARAM},
                  '{`RTCCA_INIT_PARAM, `RTCCA_INIT_PARAM, `RTCCA_INIT_PARAM}};
    else
      for (int i = 0; i < 2; i++)
        for (int j = 0; j < 3; j++)
          par_ff[i][j] <= init ? `RTCCA_INIT_PARAM : par_wr[i][j] ? pwdata[7:0] : par_ff[i][j];
  end

  // Output A mode table with passthrough override
  wire rtcca_mode_t mode_a = rtcca_mode_of(1'b1, stat2_ff[4], stat2_ff[5], stat2_ff[6],
                                           stat2_ff[7]);
  wire rtcca_mode_t mode_b = rtcca_mode_of(1'b0, 1'b0, stat2_ff[1], stat2_ff[2], stat2_ff[3]);
  rtcca_mode_t mode [2];
  assign mode[0] = mode_a;
  assign mode[1] = mode_b;

  ////////////////////////////////////////////////////////////////////////
  // Timebase and calendar

  logic       osc_ff;
  logic [14:0] pre_ff;
  rtcca_cal_t cal_ff;
  rtcca_cal_t nxt_cal;
  rtcca_cal_t snap_ff;
  logic       min_evt_ff;

  // Oscillator input is synchronous to pclk, one flop gives the edge
  wire osc_rise = osc_32k & ~osc_ff;
  // One second per full prescaler turn
  wire tick     = osc_rise & (pre_ff == `RTCCA_PRE_LAST);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_ff <= 1'b0;
      pre_ff <= '0;
    end
    else
    begin
      osc_ff <= osc_32k;
      pre_ff <= init ? 15'h0000 : osc_rise ? pre_ff + 15'h0001 : pre_ff;
    end
  end

  wire [7:0] inc_sec = rtcca_bcd_inc({1'b0, cal_ff.sec});
  wire [7:0] inc_min = rtcca_bcd_inc({1'b0, cal_ff.min});
  wire [7:0] inc_hr  = rtcca_bcd_inc({2'b00, cal_ff.hour});
  wire [7:0] inc_day = rtcca_bcd_inc({2'b00, cal_ff.day});
  wire [7:0] inc_mo  = rtcca_bcd_inc({3'b000, cal_ff.month});
  wire [7:0] inc_yr  = rtcca_bcd_inc(cal_ff.year);
  wire [5:0] mlen    = rtcca_month_len(cal_ff.month, cal_ff.year);
  wire       hr_top  = fmt24_ff ? (cal_ff.hour == 6'h23) : (cal_ff.hour == 6'h11);

  wire sec_c = tick & (cal_ff.sec == 7'h59);
  wire min_c = sec_c & (cal_ff.min == 7'h59);
  wire hr_w  = min_c & hr_top;
  wire hr_c  = hr_w & (fmt24_ff | cal_ff.pm);
  // Month length decides the day wrap
  wire day_c = hr_c & (cal_ff.day == mlen);
  wire mon_c = day_c & (cal_ff.month == 5'h12);
  // Afternoon bit as seen by software
  wire pm_now = fmt24_ff ? (cal_ff.hour >= 6'h12) : cal_ff.pm;

  // Seconds and minutes wrap at 59, seven bits kept
  assign nxt_cal.sec  = (wdone & addr_ok & hit_se) ? wb[6:0]
                      : tick ? (sec_c ? 7'h00 : inc_sec[6:0]) : cal_ff.sec;
  assign nxt_cal.min  = (wdone & addr_ok & hit_mi) ? wb[6:0]
                      : sec_c ? (min_c ? 7'h00 : inc_min[6:0]) : cal_ff.min;
  assign nxt_cal.hour = (wdone & addr_ok & hit_hr) ? wb[5:0]
                      : min_c ? (hr_w ? 6'h00 : inc_hr[5:0]) : cal_ff.hour;
  // Written afternoon bit only counts in 12-hour mode
  assign nxt_cal.pm   = (wdone & addr_ok & hit_hr) ? (wb[6] & ~fmt24_ff)
                      : (hr_w & ~fmt24_ff) ? ~cal_ff.pm : cal_ff.pm;
  assign nxt_cal.wday = (wdone & addr_ok & hit_wd) ? wb[2:0]
                      : hr_c ? ((cal_ff.wday == 3'h6) ? 3'h0 : cal_ff.wday + 3'h1) : cal_ff.wday;
  assign nxt_cal.day  = (wdone & addr_ok & hit_dy) ? wb[5:0]
                      : hr_c ? (day_c ? 6'h01 : inc_day[5:0]) : cal_ff.day;
  assign nxt_cal.month = (wdone & addr_ok & hit_mo) ? wb[4:0]
                       : day_c ? (mon_c ? 5'h01 : inc_mo[4:0]) : cal_ff.month;
  assign nxt_cal.year = (wdone & addr_ok & hit_yr) ? wb
                      : mon_c ? ((cal_ff.year == 8'h99) ? 8'h00 : inc_yr) : cal_ff.year;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cal_ff <= '{`RTCCA_INIT_YEAR, `RTCCA_INIT_MONTH, `RTCCA_INIT_DAY, 3'h0, 6'h00, 1'b0,
                  7'h00, 7'h00};
    else if (init)
      cal_ff <= '{`RTCCA_INIT_YEAR, `RTCCA_INIT_MONTH, `RTCCA_INIT_DAY, 3'h0, 6'h00, 1'b0,
                  7'h00, 7'h00};
    else
      cal_ff <= nxt_cal;
  end

  // Snapshot taken when a calendar or time-only read starts
  wire snap_take = setup & ~pwrite & (hit_yr | hit_hr);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      snap_ff <= '0;
    else if (snap_take)
      snap_ff <= '{cal_ff.year, cal_ff.month, cal_ff.day, cal_ff.wday, cal_ff.hour, pm_now,
                   cal_ff.min, cal_ff.sec};
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarms and output pins

  logic [1:0] hit_ff;
  logic [1:0] edge_ff;
  logic [1:0] pin_ff;
  wire  [4:0] fclk = {pre_ff[14], pre_ff[13], pre_ff[12], pre_ff[11], pre_ff[10]};

  // Compare one cycle after the carry so the new minute is settled
  wire min_c_evt = sec_c;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      min_evt_ff <= 1'b0;
    else
      min_evt_ff <= min_c_evt;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_out
      wire [7:0] aw = rtcca_rev8(par_ff[gi][0]);
      wire [7:0] ah = rtcca_rev8(par_ff[gi][1]);
      wire [7:0] am = rtcca_rev8(par_ff[gi][2]);
      // Only fields marked valid are compared
      wire match = (~aw[7] | (aw[2:0] == cal_ff.wday))
                 & (~ah[7] | (ah[6:0] == {pm_now, cal_ff.hour}))
                 & (~am[7] | (am[6:0] == cal_ff.min));
      assign alarm_set[1-gi] = min_evt_ff & (mode[gi] == OM_ALARM) & match;
      // AND of the selected frequency clocks, weight order follows B7 = 1 Hz
      wire [4:0] fsel    = par_ff[gi][0][7:3];
      wire       freq_on = (|fsel) & (&(~fsel | fclk));
      logic      act;

      // Alarm level holds until software leaves alarm mode
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          hit_ff[gi]  <= 1'b0;
          edge_ff[gi] <= 1'b0;
        end
        else
        begin
          hit_ff[gi]  <= (mode[gi] == OM_ALARM) & (alarm_set[1-gi] | hit_ff[gi]);
          edge_ff[gi] <= (mode[gi] == OM_EDGE) & ((min_evt_ff) | (edge_ff[gi] & ~s1_rd));
        end
      end

      // Mode picks what drives the pin
      always_comb
      begin
        act = 1'b0;
        unique case (mode[gi])
          OM_OFF:   act = 1'b0;
          OM_FREQ:  act = freq_on;
          OM_EDGE:  act = edge_ff[gi];
          OM_PER1:  act = (cal_ff.sec < 7'h30);
          OM_ALARM: act = hit_ff[gi];
          OM_PER2:  act = (cal_ff.sec == 7'h00) & (pre_ff < `RTCCA_PER2_TICKS);
          OM_OSC:   act = osc_ff;
        endcase
      end

      // Open-drain style: low while active
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          pin_ff[gi] <= 1'b1;
        else
          pin_ff[gi] <= ~act;
      end
    end
  endgenerate

  assign out_a_n = pin_ff[0];
  assign out_b_n = pin_ff[1];

  ////////////////////////////////////////////////////////////////////////
  // Read mux and bus response

  // Unused bits read zero, init bit always zero
  wire [7:0] s1_val = {1'b0, fmt24_ff, scratch_ff, alarm_flag_ff, low_ff, pwr_ff};
  // Calendar bytes in bus order, weight 1 at B7
  wire [7:0] rd_byte =
      hit_s1 ? s1_val
    : hit_s2 ? stat2_ff
    : hit_yr ? rtcca_rev8(cal_ff.year)
    : hit_mo ? rtcca_rev8({3'b000, snap_ff.month})
    : hit_dy ? rtcca_rev8({2'b00, snap_ff.day})
    : hit_wd ? rtcca_rev8({5'h00, snap_ff.wday})
    // Time-only read opens at the hour byte
    : hit_hr ? rtcca_rev8({1'b0, pm_now, cal_ff.hour})
    : hit_mi ? rtcca_rev8({1'b0, snap_ff.min})
    : hit_se ? rtcca_rev8({1'b0, snap_ff.sec})
    : hit_pa[0] ? par_ff[0][0] : hit_pa[1] ? par_ff[0][1] : hit_pa[2] ? par_ff[0][2]
    : hit_pb[0] ? par_ff[1][0] : hit_pb[1] ? par_ff[1][1] : hit_pb[2] ? par_ff[1][2]
    : 8'h00;

  // No wait state: data captured in setup, answer in first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff  <= setup;
      prdata_ff  <= (setup & ~pwrite & addr_ok) ? {24'h000000, rd_byte} : prdata_ff;
      pslverr_ff <= setup & ~addr_ok;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  AST_SEC_BCD: assert property (@(posedge pclk) disable iff (!presetn)
    (cal_ff.sec[6:4] <= 3'h5) && (cal_ff.sec[3:0] <= 4'h9) && (cal_ff.min[6:4] <= 3'h5))
    else $error("second or minute out of BCD range");
  AST_WDAY_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    (hr_c && cal_ff.wday == 3'h6 && !wdone && !init) |=> (cal_ff.wday == 3'h0))
    else $error("weekday did not wrap to zero");
  AST_FEB_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    (cal_ff.month == 5'h02 && cal_ff.year[0] && hr_c && cal_ff.day == 6'h28 && !wdone
     && !init) |=> (cal_ff.day == 6'h01 && cal_ff.month == 5'h03))
    else $error("February of a common year overran day 28");
  AST_YEAR_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    (mon_c && cal_ff.year == 8'h99 && !wdone && !init) |=> (cal_ff.year == 8'h00))
    else $error("year did not wrap from 99");
  AST_PWR_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (s1_rd && prdata_ff[`RTCCA_S1_PWR]) |=> !pwr_ff)
    else $error("power-up flag survived its read");
  AST_LOW_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    (low_ff && !s1_rd && !init) |=> low_ff)
    else $error("supply-low flag dropped without a read");
  AST_INIT_RD0: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit_s1) |=> (prdata_ff[`RTCCA_S1_INIT] == 1'b0) && pready_ff)
    else $error("initialise bit read as one");
  AST_ALARM_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (alarm_set[0] && !init) |=> alarm_flag_ff[0] ##1 (hit_ff[1] || mode_b != OM_ALARM))
    else $error("alarm match did not raise flag and pin state");
  AST_OSC_PASS: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_a == OM_OSC) |=> (out_a_n == !$past(osc_ff)))
    else $error("passthrough output does not follow oscillator");
  AST_SNAP_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !snap_take |=> $stable(snap_ff))
    else $error("snapshot changed without a read start");

  COV_ALARM: cover property (@(posedge pclk) disable iff (!presetn) alarm_set[1]);
  COV_YEAR_ROLL: cover property (@(posedge pclk) disable iff (!presetn) mon_c);
  COV_INIT: cover property (@(posedge pclk) disable iff (!presetn) init);

endmodule

// *** test/rtcca_osc_src.sv ***
// Oscillator and supply detector standing outside the core
module rtcca_osc_src (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [15:0] n_ticks,
  input  wire logic        low_req,
  output logic             osc_32k,
  output logic             busy,
  output logic             supply_low_det
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] left_ff;
  ////////////////////////////////////////////////////////////////
  // Burst of ticks; idle low so no stray edge between bursts
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      osc_32k <= 1'b0;
      left_ff <= 16'h0000;
    end
    else if (start)
      left_ff <= n_ticks;
    else if (osc_32k)
      osc_32k <= 1'b0;
    else if (left_ff != 16'h0000)
    begin
      osc_32k <= 1'b1;
      left_ff <= left_ff - 16'h0001;
    end
  // Busy until the last edge has fallen
  assign busy           = (left_ff != 16'h0000) | osc_32k;
  assign supply_low_det = low_req;
endmodule

// *** test/tb_top.sv ***
`include "rtcca_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, osc_32k, supply_low_det, out_a_n, out_b_n;
  logic start = 0, low_req = 0, busy;
  logic [15:0] n_ticks = 16'h8000;
  int n_mismatch = 0, compares = 0;
  always #20 pclk = ~pclk;
  rtcca_regs rtcca_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_32k(osc_32k),
    .supply_low_det(supply_low_det), .out_a_n(out_a_n), .out_b_n(out_b_n));
  rtcca_osc_src rtcca_osc_src_inst (.pclk(pclk), .presetn(presetn), .start(start),
    .n_ticks(n_ticks), .low_req(low_req), .osc_32k(osc_32k), .busy(busy),
    .supply_low_det(supply_low_det));
  ////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Weight-1 bit travels in bus bit 7
  function automatic logic [7:0] rv(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
      rv[i] = v[7-i];
  endfunction
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20)
    begin
      n_mismatch++;
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 8'h00, q, e);
    chk(q, {24'h0, x});
  endtask
  ////////////////////////////////////////////////////////////////
  // Power-on values, then init keeps bits 6..4 only
  task automatic t_reset_init();
    rd(`RTCCA_OFF_STAT1, 8'h01); // power flag
    rd(`RTCCA_OFF_STAT1, 8'h00); // cleared by read
    rd(`RTCCA_OFF_STAT2, 8'h80); // 1 Hz on A
    rd(`RTCCA_OFF_PA0, 8'h80); // frequency byte
    wr(`RTCCA_OFF_STAT1, 8'hF0);
    rd(`RTCCA_OFF_STAT1, 8'h70); // init bit reads 0
    rd(`RTCCA_OFF_STAT2, 8'h00); // modes cleared
  endtask
  // Unmapped word and unused weekday bits
  task automatic t_refuse_unused();
    logic [31:0] q;
    logic e;
    apb(1'b0, 8'h3C, 8'h00, q, e);
    chk({31'h0, e}, 32'h1); // no target
    wr(`RTCCA_OFF_WDAY, 8'hBF);
    rd(`RTCCA_OFF_YEAR, 8'h00); // year after init
    rd(`RTCCA_OFF_WDAY, 8'hA0); // unused bits read 0
  endtask
  // 28 Feb 2023 23:59:59, weekday 6, one second on, alarm B at 00:00
  task automatic t_rollover_alarm();
    int n;
    wr(`RTCCA_OFF_YEAR, rv(8'h23));
    wr(`RTCCA_OFF_MONTH, rv(8'h02));
    wr(`RTCCA_OFF_DAY, rv(8'h28));
    wr(`RTCCA_OFF_WDAY, rv(8'h06));
    wr(`RTCCA_OFF_HOUR, rv(8'h23));
    wr(`RTCCA_OFF_MIN, rv(8'h59));
    wr(`RTCCA_OFF_SEC, rv(8'h59));
    wr(`RTCCA_OFF_STAT2, 8'h02); // alarm mode first, test bit 0
    wr(`RTCCA_OFF_PB0, 8'h00);
    wr(`RTCCA_OFF_PB1, 8'h01);
    wr(`RTCCA_OFF_PB2, 8'h01);
    @(posedge pclk);
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    @(posedge pclk);
    for (n = 0; n < 70000 && busy === 1'b1; n++)
      @(posedge pclk);
    if (n == 70000)
    begin
      n_mismatch++;
      conclude();
    end
    rd(`RTCCA_OFF_HOUR, 8'h00); // midnight, morning
    rd(`RTCCA_OFF_MIN, 8'h00); // minute carry
    rd(`RTCCA_OFF_SEC, 8'h00); // one second
    rd(`RTCCA_OFF_YEAR, rv(8'h23)); // year kept
    rd(`RTCCA_OFF_MONTH, rv(8'h03)); // non-leap February
    rd(`RTCCA_OFF_DAY, rv(8'h01)); // day wraps
    rd(`RTCCA_OFF_WDAY, 8'h00); // weekday wraps
    chk({31'h0, out_b_n}, 32'h0); // alarm pin low
    rd(`RTCCA_OFF_STAT1, 8'h74); // alarm B flag
    rd(`RTCCA_OFF_STAT1, 8'h70); // cleared by read
    wr(`RTCCA_OFF_STAT2, 8'h00); // leave alarm mode
    repeat (3) @(posedge pclk);
    chk({31'h0, out_b_n}, 32'h1); // pin released
  endtask
  // Detector pulse must leave a sticky flag
  task automatic t_supply();
    @(posedge pclk);
    low_req <= 1'b1;
    repeat (4) @(posedge pclk);
    low_req <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(`RTCCA_OFF_STAT1, 8'h72); // sticky after recovery
    rd(`RTCCA_OFF_STAT1, 8'h70); // read clears
  endtask
  // Passthrough: one low pin cycle per oscillator pulse
  task automatic t_osc_pass();
    int n, lows;
    lows = 0;
    wr(`RTCCA_OFF_STAT2, 8'h10);
    n_ticks <= 16'h0008;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    for (n = 0; n < 40; n++)
    begin
      @(posedge pclk);
      if (out_a_n === 1'b0)
        lows++;
    end
    chk(lows, 32'h8); // pin follows oscillator
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_init();
    t_refuse_unused();
    t_rollover_alarm();
    t_supply();
    t_osc_pass();
    conclude();
  end
endmodule
